// ==== core/cpw_timer.sv ====
// complementary three-phase pwm timer with ahb-lite registers and standby
`timescale 1ns/1ns
module cpw_timer (
  input wire logic sys_clk_in, // 125 MHz clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic hsel_in, // ahb select
  input wire logic [31:0] haddr_in, // ahb address
  input wire logic [1:0] htrans_in, // ahb transfer type
  input wire logic hwrite_in, // ahb write
  input wire logic [2:0] hsize_in, // ahb size, words only
  input wire logic [31:0] hwdata_in, // ahb write data
  input wire logic hready_in, // ahb bus ready
  output logic hreadyout_out, // ahb slave ready
  output logic hresp_out, // ahb response, always okay
  output logic [31:0] hrdata_out, // ahb read data
  input wire logic clock_in_pin_in, // external count clock
  input wire logic cutoff_irq_pin_in, // cutoff or interrupt pin
  output logic phase_u_pos_pin_out, // pwm1 normal phase
  output logic phase_u_neg_pin_out, // pwm1 counter phase
  output logic phase_v_pos_pin_out, // pwm2 normal phase
  output logic phase_v_neg_pin_out, // pwm2 counter phase
  output logic phase_w_pos_pin_out, // pwm3 normal phase
  output logic phase_w_neg_pin_out, // pwm3 counter phase
  output logic half_period_toggle_pin_out, // half period square wave
  output logic [9:0] evt_pulse_out, // one-cycle event pulses
  output logic irq_out // level interrupt
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] clkp_q;
  logic [1:0] cutp_q;
  logic clk_last_q;
  logic cut_last_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      clkp_q <= 2'h0;
      cutp_q <= 2'h3;
      clk_last_q <= 1'b0;
      cut_last_q <= 1'b1;
    end
    else
    begin
      clkp_q <= {clkp_q[0], clock_in_pin_in}; // R05
      cutp_q <= {cutp_q[0], cutoff_irq_pin_in};
      clk_last_q <= clkp_q[1];
      cut_last_q <= cutp_q[1];
    end
  end
  wire ext_rise = clkp_q[1] & ~clk_last_q;
  wire pin_fall = ~cutp_q[1] & cut_last_q; // R06

  // ------------------------------------------------------------
  // ahb-lite slave: writes zero wait, reads one wait state
  // ------------------------------------------------------------
  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] addr_q;
  logic [31:0] hrdata_q;
  logic cmp_sel_q;
  logic stby_q;
  logic rsvd_q;
  wire acc = hsel_in & htrans_in[1] & hready_in;
  wire in_blk = (addr_q >= cpw_pkg::BLK_LO) && (addr_q <= cpw_pkg::BLK_HI);
  wire blocked = stby_q & in_blk; // R12
  wire wr_ok = wr_pend_q & ~blocked;
  wire is_cmp = addr_q[11:4] == cpw_pkg::CMP_OFS[11:4];
  wire wr_stby = wr_ok & (addr_q == cpw_pkg::STBY_OFS);
  wire wr_start = wr_ok & (addr_q == cpw_pkg::START_OFS);
  wire wr_ctrl = wr_ok & (addr_q == cpw_pkg::CTRL_OFS);
  wire wr_c0 = wr_ok & (addr_q == cpw_pkg::CNT0_OFS);
  wire wr_c1 = wr_ok & (addr_q == cpw_pkg::CNT1_OFS);
  wire wr_stat = wr_ok & (addr_q == cpw_pkg::STAT_OFS);
  wire wr_mask = wr_ok & (addr_q == cpw_pkg::MASK_OFS);
  assign hreadyout_out = ~rd_pend_q;
  assign hresp_out = 1'b0;
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= acc & hwrite_in;
      rd_pend_q <= acc & ~hwrite_in;
      if (acc)
        addr_q <= haddr_in[11:0];
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [1:0] start_q;
  logic [11:0] ctrl_q;
  logic [15:0] period_q;
  cpw_cmp_if cif ();
  cpw_cmp_bank u_bank (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .cif(cif)
  );
  assign cif.wr_en = wr_ok & is_cmp;
  assign cif.wr_idx = addr_q[3:2];
  assign cif.wr_data = hwdata_in;
  assign cif.rd_en = rd_pend_q & is_cmp;
  assign cif.rd_idx = addr_q[3:2];
  wire run0 = start_q[0];
  wire run1 = start_q[1];
  wire [15:0] m_cmp = cif.vals[0][15:0];
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      stby_q <= cpw_pkg::STBY_RST[cpw_pkg::STBY_BIT];
      rsvd_q <= cpw_pkg::STBY_RST[cpw_pkg::RSVD_BIT];
      start_q <= 2'h0;
      ctrl_q <= cpw_pkg::CTRL_RST;
      period_q <= cpw_pkg::CMP_RST[15:0];
    end
    else
    begin
      if (wr_stby)
      begin
        stby_q <= hwdata_in[cpw_pkg::STBY_BIT]; // R11
        rsvd_q <= hwdata_in[cpw_pkg::RSVD_BIT]; // R15
      end
      if (wr_start)
        start_q <= hwdata_in[1:0];
      // period only latched at the start edge, later edits wait
      if (wr_start & hwdata_in[0] & ~run0)
        period_q <= m_cmp; // R10
      if (wr_ctrl)
        ctrl_q <= hwdata_in[11:0]; // R09
    end
  end

  // ------------------------------------------------------------
  // count source divider, ticks are one-cycle enables
  // ------------------------------------------------------------
  logic [4:0] div_q;
  wire [2:0] css = ctrl_q[2:0];
  wire [4:0] dmask = (css == cpw_pkg::CSS_F2) ? cpw_pkg::DIV2_MSK :
                     (css == cpw_pkg::CSS_F4) ? cpw_pkg::DIV4_MSK :
                     (css == cpw_pkg::CSS_F8) ? cpw_pkg::DIV8_MSK :
                     (css == cpw_pkg::CSS_F32) ? cpw_pkg::DIV32_MSK : 5'h00;
  wire src_tick = (css == cpw_pkg::CSS_EXT) ? ext_rise : ((div_q & dmask) == dmask);
  // standby masks the count source tick, the divider keeps running
  wire tick = src_tick & ~stby_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      div_q <= 5'h00;
    else
      div_q <= div_q + 5'h01;
  end

  // ------------------------------------------------------------
  // counters: up one past the period, down until counter one underflows
  // ------------------------------------------------------------
  logic [15:0] c0_q;
  logic [15:0] c1_q;
  logic tog_q;
  cpw_pkg::cpw_dir_t dir_q;
  wire up = dir_q == cpw_pkg::DIR_UP;
  wire top = up & ({1'b0, c0_q} == {1'b0, period_q} + 17'h0_0001); // R17
  wire udf = ~up & (c1_q == 16'h0000);
  wire step_up = up & ~top;
  wire [15:0] c0_nx = step_up ? c0_q + 16'h0001 : c0_q - 16'h0001;
  wire [15:0] c1_nx = udf ? 16'hffff : (step_up ? c1_q + 16'h0001 : c1_q - 16'h0001);
  wire top_ev = tick & run0 & top;
  wire udf_ev = tick & run1 & udf;
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      c0_q <= 16'h0000;
      c1_q <= 16'h0000;
      dir_q <= cpw_pkg::DIR_UP;
      tog_q <= 1'b0;
    end
    else
    begin
      if (wr_c0)
        c0_q <= hwdata_in[15:0]; // R08
      else if (tick & run0)
        c0_q <= c0_nx; // R17
      if (wr_c1)
        c1_q <= hwdata_in[15:0]; // R08
      else if (tick & run1)
        c1_q <= c1_nx;
      case (dir_q)
        cpw_pkg::DIR_UP: if (top_ev) dir_q <= cpw_pkg::DIR_DN;
        cpw_pkg::DIR_DN: if (udf_ev) dir_q <= cpw_pkg::DIR_UP;
        default: dir_q <= cpw_pkg::DIR_UP;
      endcase
      if (top_ev | udf_ev)
        tog_q <= ~tog_q; // R04
    end
  end
  assign half_period_toggle_pin_out = tog_q;

  // ------------------------------------------------------------
  // events and interrupt flags
  // ------------------------------------------------------------
  logic [7:0] cmp_ev;
  logic [9:0] evt_q;
  for (genvar k = 0; k < 8; k++)
  begin : g_match
    wire [15:0] cv = cif.vals[k / 2][16 * (k % 2) +: 16];
    wire hit = ((k < 4) ? c0_q : c1_q) == cv;
    assign cmp_ev[k] = tick & ((k < 4) ? run0 : run1) & hit; // R01
  end
  wire [9:0] evt_d = {pin_fall, udf_ev, cmp_ev}; // R02
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      evt_q <= 10'h000;
    else
      evt_q <= evt_d; // R19
  end
  assign evt_pulse_out = evt_q;
  logic [9:0] stat_w;
  logic [9:0] mask_w;
  cpw_sticky #(.W(cpw_pkg::EVT_W)) u_sticky (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .set_in(evt_q),
    .clr_we_in(wr_stat),
    .mask_we_in(wr_mask),
    .wdata_in(hwdata_in[9:0]),
    .stat_out(stat_w),
    .mask_out(mask_w),
    .irq_out(irq_out)
  );

  // ------------------------------------------------------------
  // complementary outputs with dead time from the counter offset
  // ------------------------------------------------------------
  logic [2:0] pos_q;
  logic [2:0] neg_q;
  logic [2:0][15:0] duty;
  assign duty[0] = cif.vals[0][31:16];
  assign duty[1] = cif.vals[2][15:0];
  assign duty[2] = cif.vals[2][31:16];
  wire nlvl = ctrl_q[cpw_pkg::NLVL_BIT];
  wire clvl = ctrl_q[cpw_pkg::CLVL_BIT];
  wire init = ctrl_q[cpw_pkg::INIT_BIT];
  // cutoff is a level: pins stay parked while the pin is held low
  wire cut_on = ctrl_q[cpw_pkg::CUT_BIT] & ~cutp_q[1]; // R06
  wire idle = ~run0 | cut_on;
  logic [2:0] pos_d;
  logic [2:0] neg_d;
  for (genvar i = 0; i < 3; i++)
  begin : g_phase
    wire nact = up ? (c1_q > duty[i]) & (c1_q != 16'hffff) : (c1_q >= duty[i]); // R18
    wire cact = up ? (c0_q <= duty[i]) : (c0_q < duty[i]);
    assign pos_d[i] = idle ? init : (nact ? nlvl : ~nlvl); // R09
    assign neg_d[i] = idle ? init : (cact ? clvl : ~clvl);
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      pos_q <= 3'h0;
      neg_q <= 3'h0;
    end
    else
    begin
      pos_q <= pos_d; // R03
      neg_q <= neg_d;
    end
  end
  assign phase_u_pos_pin_out = pos_q[0];
  assign phase_u_neg_pin_out = neg_q[0];
  assign phase_v_pos_pin_out = pos_q[1];
  assign phase_v_neg_pin_out = neg_q[1];
  assign phase_w_pos_pin_out = pos_q[2];
  assign phase_w_neg_pin_out = neg_q[2];

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  wire [7:0] stby_byte = {1'b0, rsvd_q, 1'b0, stby_q, 4'h0}; // R15
  wire [31:0] rd_mux = blocked ? 32'h0000_0000 :
    (addr_q == cpw_pkg::STBY_OFS) ? {24'h00_0000, stby_byte} :
    (addr_q == cpw_pkg::START_OFS) ? {30'h0000_0000, start_q} :
    (addr_q == cpw_pkg::CTRL_OFS) ? {20'h0_0000, ctrl_q} :
    (addr_q == cpw_pkg::CNT0_OFS) ? {16'h0000, c0_q} : // R07
    (addr_q == cpw_pkg::CNT1_OFS) ? {16'h0000, c1_q} :
    (addr_q == cpw_pkg::STAT_OFS) ? {22'h00_0000, stat_w} :
    (addr_q == cpw_pkg::MASK_OFS) ? {22'h00_0000, mask_w} : 32'h0000_0000;
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      hrdata_q <= 32'h0000_0000;
      cmp_sel_q <= 1'b0;
    end
    else if (rd_pend_q)
    begin
      hrdata_q <= rd_mux;
      cmp_sel_q <= is_cmp & ~blocked; // R12
    end
  end
  assign hrdata_out = cmp_sel_q ? cif.rd_data : hrdata_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  stby_block_a: assert property (wr_pend_q && stby_q && addr_q == cpw_pkg::CTRL_OFS
    |=> ctrl_q == $past(ctrl_q)) else $error("write passed standby"); // R12
  cnt_load_a: assert property (wr_c0 |=> c0_q == $past(hwdata_in[15:0]))
    else $error("counter not loaded"); // R08
  cnt_read_a: assert property (rd_pend_q && !stby_q && addr_q == cpw_pkg::CNT1_OFS
    |=> hrdata_out[15:0] == $past(c1_q)) else $error("bad count read"); // R07
  udf_evt_a: assert property (udf_ev && !wr_c1 |=> evt_q[cpw_pkg::UDF_BIT] && c1_q == 16'hffff
    && dir_q == cpw_pkg::DIR_UP) else $error("underflow missed"); // R02
  toggle_half_a: assert property (top_ev || udf_ev |=> tog_q != $past(tog_q))
    else $error("no half period toggle"); // R04
  period_hold_a: assert property (run0 && $past(run0) |-> period_q == $past(period_q))
    else $error("period changed while running"); // R10
  cmp_match_a: assert property (tick && run0 && c0_q == cif.vals[0][15:0]
    |=> evt_q[0] ##1 stat_w[0]) else $error("match not flagged"); // R01
  cutoff_park_a: assert property (cut_on |=> pos_q == {3{$past(init)}}
    && neg_q == {3{$past(init)}}) else $error("cutoff not applied"); // R06
  stby_bit_a: assert property (wr_stby |=> stby_q == $past(hwdata_in[cpw_pkg::STBY_BIT])
    && stby_byte[7] == 1'b0) else $error("standby bit wrong"); // R11
  top_turn_c: cover property (top_ev ##1 dir_q == cpw_pkg::DIR_DN);
  udf_c: cover property (udf_ev);
  cutoff_c: cover property (run0 && cut_on);
  blocked_wr_c: cover property (wr_pend_q && blocked);
endmodule // cpw_timer

// ==== core/cpw_pkg.sv ====
// constants, register map and types of the complementary pwm timer
// ----------------------------------------------------------------
// Behaviour
// R01: compare match on either counter raises interrupt
// R02: second counter underflow raises interrupt
// R03: three pwm channels, normal and counter-phase pins
// R04: auxiliary pin toggles every half period
// R05: channel-A pin is only port or clock input
// R06: cutoff pin: port, interrupt or forced cutoff
// R07: counter reads return current count
// R08: counter writes load the counter
// R09: active levels and initial level are configurable
// R10: period fixed once counting starts
// R11: standby bit b4: 0 active, 1 standby
// R12: standby blocks timer register range access
// R13: software stops timer before standby
// R14: software sets count source 000b before standby
// R15: unassigned bits read 0, write 0; standby byte bit 6 (RSVD_BIT) is stored and reads back as written
// R16: software starts counters via both start flags
// R17: period is twice (m+2-p) source cycles
// R18: normal-phase active twice (m-n-p+1) cycles
// R19: each event pulses once and sets flag
// ----------------------------------------------------------------
package cpw_pkg;
  localparam logic [11:0] STBY_OFS = 12'h008;
  localparam logic [11:0] BLK_LO = 12'h134;
  localparam logic [11:0] BLK_HI = 12'h15c;
  localparam logic [11:0] START_OFS = 12'h138;
  localparam logic [11:0] CTRL_OFS = 12'h13c;
  localparam logic [11:0] CNT0_OFS = 12'h140;
  localparam logic [11:0] CNT1_OFS = 12'h144;
  localparam logic [11:0] STAT_OFS = 12'h148;
  localparam logic [11:0] MASK_OFS = 12'h14c;
  localparam logic [11:0] CMP_OFS = 12'h150;
  localparam int STBY_BIT = 4;
  localparam int RSVD_BIT = 6;
  localparam logic [7:0] STBY_RST = 8'h00;
  localparam int CSS1_LSB = 4;
  localparam int NLVL_BIT = 8;
  localparam int CLVL_BIT = 9;
  localparam int INIT_BIT = 10;
  localparam int CUT_BIT = 11;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [31:0] CMP_RST = 32'hffff_ffff;
  localparam int EVT_W = 10;
  localparam int UDF_BIT = 8;
  localparam int PIN_BIT = 9;
  localparam logic [2:0] CSS_F2 = 3'h1;
  localparam logic [2:0] CSS_F4 = 3'h2;
  localparam logic [2:0] CSS_F8 = 3'h3;
  localparam logic [2:0] CSS_F32 = 3'h4;
  localparam logic [2:0] CSS_EXT = 3'h5;
  localparam logic [4:0] DIV2_MSK = 5'h01;
  localparam logic [4:0] DIV4_MSK = 5'h03;
  localparam logic [4:0] DIV8_MSK = 5'h07;
  localparam logic [4:0] DIV32_MSK = 5'h1f;
  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DN = 2'b10} cpw_dir_t;
endpackage

// ==== core/cpw_cmp_if.sv ====
// compare register bank connection
`timescale 1ns/1ns
interface cpw_cmp_if;
  logic wr_en;
  logic [1:0] wr_idx;
  logic [31:0] wr_data;
  logic rd_en;
  logic [1:0] rd_idx;
  logic [31:0] rd_data;
  logic [3:0][31:0] vals;
  modport bank (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, vals);
  modport user (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, vals);
endinterface

// ==== core/cpw_cmp_bank.sv ====
// four words of compare values, two 16-bit compares per word
`timescale 1ns/1ns
module cpw_cmp_bank (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  cpw_cmp_if.bank cif // write, read and compare taps
);
  logic [3:0][31:0] mem_q;
  logic [31:0] rd_q;
  assign cif.vals = mem_q;
  assign cif.rd_data = rd_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      mem_q <= {4{cpw_pkg::CMP_RST}};
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      if (cif.wr_en)
        mem_q[cif.wr_idx] <= cif.wr_data;
      if (cif.rd_en)
        rd_q <= mem_q[cif.rd_idx];
    end
  end
endmodule // cpw_cmp_bank

// ==== core/cpw_sticky.sv ====
// sticky event flags, write one to clear, masked onto one interrupt
`timescale 1ns/1ns
module cpw_sticky #(parameter int W = 10) (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic [W-1:0] set_in, // event pulses
  input wire logic clr_we_in, // status write strobe
  input wire logic mask_we_in, // mask write strobe
  input wire logic [W-1:0] wdata_in, // write data
  output logic [W-1:0] stat_out, // sticky flags
  output logic [W-1:0] mask_out, // mask register
  output logic irq_out // level interrupt
);
  logic [W-1:0] stat_q;
  logic [W-1:0] mask_q;
  wire [W-1:0] clr_bits = clr_we_in ? wdata_in : '0;
  // set wins over a clear in the same cycle
  wire [W-1:0] stat_d = (stat_q & ~clr_bits) | set_in; // R19
  assign stat_out = stat_q;
  assign mask_out = mask_q;
  assign irq_out = |(stat_q & mask_q);
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      stat_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      stat_q <= stat_d;
      if (mask_we_in)
        mask_q <= wdata_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  set_wins_a: assert property (set_in[0] |=> stat_q[0]) // R19
    else $error("event flag lost");
endmodule // cpw_sticky

// ==== sim/cpw_far_side.sv ====
// far-side model: forced cutoff source and external count clock
`timescale 1ns/1ns
module cpw_far_side (
  input wire logic ext_run_in, // let the count clock run
  input wire logic cut_in, // request forced cutoff
  output logic clock_in_pin_out, // external count clock
  output logic cutoff_irq_pin_out // cutoff line
);
  // --------------------------------------
  // count clock, still between bursts
  // --------------------------------------
  // 40 ns period, phase unrelated to the system clock
  initial clock_in_pin_out = 1'b0;
  always
  begin
    #13;
    if (ext_run_in)
    begin
      clock_in_pin_out = 1'b1;
      #20;
      clock_in_pin_out = 1'b0;
      #7;
    end
  end
  // pull-up holds the line high, the source only ever pulls it low
  assign cutoff_irq_pin_out = cut_in ? 1'b0 : 1'b1;
endmodule // cpw_far_side

// ==== sim/complementary_pwm_standby_tb.sv ====
// self-checking bench of the complementary pwm timer
`timescale 1ns/1ns
`define CHK(a, e) \
  begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module complementary_pwm_standby_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_run = 1'b0;
  logic cut = 1'b0;
  logic hready, hresp, tog, ext_clk, cut_pin, irq;
  logic [31:0] hrdata, q, v;
  logic [5:0] pins;
  logic [9:0] evt;
  int mismatches = 0;
  int compares = 0;
  int seed = 83;
  int pulses = 0;
  int per, hu, hn, bad, e8, hu0, hn0, m, n, p, i;
  always #4 clk = ~clk;
  always @(posedge ext_clk) pulses++;
  cpw_timer dut (.sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .clock_in_pin_in(ext_clk), .cutoff_irq_pin_in(cut_pin),
    .phase_u_pos_pin_out(pins[0]), .phase_u_neg_pin_out(pins[1]),
    .phase_v_pos_pin_out(pins[2]), .phase_v_neg_pin_out(pins[3]),
    .phase_w_pos_pin_out(pins[4]), .phase_w_neg_pin_out(pins[5]),
    .half_period_toggle_pin_out(tog), .evt_pulse_out(evt), .irq_out(irq));
  cpw_far_side far (.ext_run_in(ext_run), .cut_in(cut), .clock_in_pin_out(ext_clk),
    .cutoff_irq_pin_out(cut_pin));
  // --------------------------------------
  // expectations, bus and measurement
  // --------------------------------------
  function automatic int pwm_period(int m, int p);
    return 2 * (m + 2 - p);
  endfunction
  function automatic int act_width(int a, int b);
    return 2 * (a - b + 1);
  endfunction
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  // one full period from a toggle edge, pins sampled every cycle
  task automatic measure;
    logic t;
    int k;
    per = 0;
    hu = 0;
    hn = 0;
    bad = 0;
    e8 = 0;
    t = tog;
    for (k = 0; k < 500 && tog === t; k++) @(posedge clk);
    repeat (2)
    begin
      t = tog;
      do
      begin
        @(posedge clk);
        per++;
        hu += (pins[0] === 1'b1);
        hn += (pins[1] === 1'b1);
        bad += (pins[2] !== pins[0] || pins[4] !== pins[0]);
        bad += (pins[3] !== pins[1] || pins[5] !== pins[1]);
        e8 += (evt[8] === 1'b1);
      end
      while (tog === t && per < 500);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    conclude;
  end
  // --------------------------------------
  // test sequence
  // --------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, cpw_pkg::STBY_OFS, 32'h0);
    `CHK(q[7:0], cpw_pkg::STBY_RST);
    bus(1'b0, cpw_pkg::CMP_OFS, 32'h0);
    `CHK(q, cpw_pkg::CMP_RST);
    $display("test reset values done");
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed);
      bus(1'b1, i[0] ? cpw_pkg::CNT1_OFS : cpw_pkg::CNT0_OFS, {16'h0, v[15:0]});
      bus(1'b0, i[0] ? cpw_pkg::CNT1_OFS : cpw_pkg::CNT0_OFS, 32'h0);
      `CHK(q[15:0], v[15:0]);
    end
    $display("test counter access done");
    bus(1'b1, cpw_pkg::CNT0_OFS, 32'h0);
    bus(1'b1, cpw_pkg::CTRL_OFS, {29'h0, cpw_pkg::CSS_EXT});
    bus(1'b1, cpw_pkg::START_OFS, 32'h3);
    pulses = 0;
    ext_run <= 1'b1;
    repeat (50) @(posedge clk);
    ext_run <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b0, cpw_pkg::CNT0_OFS, 32'h0);
    `CHK(q[15:0], pulses[15:0]);
    bus(1'b1, cpw_pkg::START_OFS, 32'h0);
    $display("test external clock done");
    v = $random(seed);
    m = 40;
    p = 3;
    n = 8 + v[3:0];
    bus(1'b1, cpw_pkg::CMP_OFS, {n[15:0], m[15:0]});
    bus(1'b1, cpw_pkg::CMP_OFS + 12'h8, {n[15:0], n[15:0]});
    bus(1'b1, cpw_pkg::CNT0_OFS, p);
    bus(1'b1, cpw_pkg::CNT1_OFS, 32'h0);
    bus(1'b1, cpw_pkg::STAT_OFS, 32'h3ff);
    bus(1'b1, cpw_pkg::MASK_OFS, 32'h3ff);
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h0);
    bus(1'b1, cpw_pkg::START_OFS, 32'h3);
    measure;
    `CHK(per, pwm_period(m, p));
    `CHK(hu == act_width(m - p, n) || per - hu == act_width(m - p, n), 1'b1);
    `CHK(hn == act_width(n, p) || per - hn == act_width(n, p), 1'b1);
    `CHK(bad, 0);
    `CHK(e8, 1);
    bus(1'b1, cpw_pkg::CMP_OFS, {n[15:0], m[15:0] + 16'ha});
    measure;
    `CHK(per, pwm_period(m, p));
    hu0 = hu;
    hn0 = hn;
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h300);
    measure;
    `CHK(hu, per - hu0);
    `CHK(hn, per - hn0);
    bus(1'b0, cpw_pkg::STAT_OFS, 32'h0);
    `CHK(q[9:0] & 10'h133, 10'h133);
    `CHK(irq, 1'b1);
    bus(1'b1, cpw_pkg::START_OFS, 32'h0);
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h400);
    repeat (4) @(posedge clk);
    `CHK(pins, 6'h3f);
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(pins, 6'h00);
    bus(1'b1, cpw_pkg::STAT_OFS, 32'h3ff);
    bus(1'b0, cpw_pkg::STAT_OFS, 32'h0);
    `CHK(q, 32'h0);
    `CHK(irq, 1'b0);
    $display("test pwm waveform done");
    bus(1'b1, cpw_pkg::MASK_OFS, 32'h0);
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h800);
    bus(1'b1, cpw_pkg::START_OFS, 32'h3);
    repeat (20) @(posedge clk);
    cut <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(pins, 6'h00);
    bus(1'b0, cpw_pkg::STAT_OFS, 32'h0);
    `CHK(q[9], 1'b1);
    `CHK(irq, 1'b0);
    bus(1'b1, cpw_pkg::MASK_OFS, 32'h200);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1);
    bus(1'b1, cpw_pkg::STAT_OFS, 32'h200);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0);
    cut <= 1'b0;
    $display("test forced cutoff done");
    bus(1'b1, cpw_pkg::START_OFS, 32'h0);
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h0);
    bus(1'b1, cpw_pkg::CNT0_OFS, 32'h55);
    bus(1'b1, cpw_pkg::STBY_OFS, 32'h10);
    bus(1'b0, cpw_pkg::STBY_OFS, 32'h0);
    `CHK(q[7:0], 8'h10);
    bus(1'b1, cpw_pkg::CTRL_OFS, 32'h123);
    bus(1'b1, cpw_pkg::CNT0_OFS, 32'h1234);
    bus(1'b0, cpw_pkg::CNT0_OFS, 32'h0);
    `CHK(q, 32'h0);
    bus(1'b0, cpw_pkg::CMP_OFS + 12'hc, 32'h0);
    `CHK(q, 32'h0);
    `CHK(hresp, 1'b0);
    bus(1'b1, cpw_pkg::STBY_OFS, 32'h0);
    bus(1'b0, cpw_pkg::CNT0_OFS, 32'h0);
    `CHK(q[15:0], 16'h0055);
    bus(1'b0, cpw_pkg::CTRL_OFS, 32'h0);
    `CHK(q, 32'h0);
    bus(1'b0, 12'h200, 32'h0);
    `CHK(q, 32'h0);
    $display("test standby done");
    conclude;
  end
endmodule // complementary_pwm_standby_tb
